// ---- hw/mcc_regs.svh ----
// register offsets, field positions, reset values and codes for the monitor and calibration control bank
// assumes inclusion by the package and the design files, definitions only
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH
`define MCC_ADDR_SYS 8'h09
`define MCC_ADDR_OFS_LO 8'h0A
`define MCC_ADDR_OFS_MID 8'h0B
`define MCC_ADDR_OFS_HI 8'h0C
`define MCC_ADDR_GAIN_LO 8'h0D
`define MCC_ADDR_GAIN_MID 8'h0E
`define MCC_ADDR_GAIN_HI 8'h0F
`define MCC_ADDR_PIN_IO 8'h10
`define MCC_RST_SYS 8'h10
`define MCC_RST_ZERO 8'h00
`define MCC_RST_GAIN_HI 8'h40
`define MCC_MON_MSB 7
`define MCC_MON_LSB 5
`define MCC_CAL_MSB 4
`define MCC_CAL_LSB 3
`define MCC_BIT_TIMEOUT 2
`define MCC_BIT_CRC 1
`define MCC_BIT_STATUS 0
`define MCC_MON_OFF 3'h0
`define MCC_MON_SHORT 3'h1
`define MCC_MON_TEMP 3'h2
`define MCC_MON_AVDD 3'h3
`define MCC_MON_DVDD 3'h4
`define MCC_MON_BO_LOW 3'h5
`define MCC_MON_BO_MID 3'h6
`define MCC_MON_BO_HIGH 3'h7
`define MCC_AVG_1 5'h01
`define MCC_AVG_4 5'h04
`define MCC_AVG_8 5'h08
`define MCC_AVG_16 5'h10
`define MCC_AMP_ON 2'h1
`define MCC_GAIN_UNITY 3'h0
`define MCC_GAIN_MAX_TEMP 3'h2
`define MCC_CRC_POLY 8'h07
`define MCC_CRC_INIT 8'h00
`define MCC_FRAME_LAST 3'h4
`endif

// ---- hw/mcc_pkg.sv ----
// types shared by the monitor and calibration control bank
// assumes the constants header for widths and codes
`include "mcc_regs.svh"
package mcc_pkg;
  typedef struct packed {
    logic [2:0] monitor_select;
    logic [1:0] calibration_average_count;
    logic timeout_enable;
    logic checksum_enable;
    logic status_prefix_enable;
  } mcc_sys_t;

  typedef struct packed {
    logic mid_short;
    logic temp_sense;
    logic avdd_mon;
    logic dvdd_mon;
    logic [2:0] burnout_sel;
    logic mux_open;
    logic [2:0] eff_gain;
  } mcc_analog_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } mcc_byte_t;

  typedef enum logic [4:0] {
    MCC_IDLE = 5'h01,
    MCC_STAT = 5'h02,
    MCC_DATA = 5'h04,
    MCC_CHK = 5'h08,
    MCC_DONE = 5'h10
  } mcc_state_t;
endpackage : mcc_pkg

// ---- hw/mcc_crc8.sv ----
// one-byte crc-8 update step for the conversion frame checksum
// assumes the caller holds the running value and feeds bytes in send order
`timescale 1ns/1ns
`include "mcc_regs.svh"
module mcc_crc8 (
  input wire logic [7:0] crc_in, // running checksum
  input wire logic [7:0] data_in, // byte to fold in
  output logic [7:0] crc_out // updated checksum
);
  logic [7:0] stage [0:8];
  assign stage[0] = crc_in ^ data_in;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign stage[i+1] = stage[i][7] ? ((stage[i] << 1) ^ `MCC_CRC_POLY) : (stage[i] << 1);
    end
  endgenerate
  assign crc_out = stage[8];
endmodule : mcc_crc8

// ---- hw/mcc_ctrl.sv ----
// monitor select, calibration averaging, framing options and trim value registers
// assumes a single-clock register port and a converter core giving result, status and result-ready strobes
//
// Function
// - code 000 no monitor; 001 shorts amplifier inputs to mid-supply, user gain.
// - code 010 routes temperature sensor; host enables amplifier with field 01.
// - code 011 measures analog supply over four; 100 digital supply over four.
// - codes 101, 110, 111 enable burn-out sources 0.2, 1, 10 uA.
// - short, temperature or supply monitor opens all input multiplexer switches.
// - supply monitor forces effective amplifier gain to one.
// - averaging codes 00..11 pick 1, 4, 8, 16 samples; reset 10.
// - bit 2 enables serial timeout; cleared at reset.
// - checksum bit appends crc over result and status byte when present.
// - bit 0 prepends a status byte to each result; cleared at reset.
// - 24-bit offset trim in three bytes, low byte first, reset zero.
// - 24-bit gain trim in three bytes, top byte resets 40h, others zero.
`timescale 1ns/1ns
`include "mcc_regs.svh"
module mcc_ctrl (
  input wire logic clk, // 20 MHz clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic [1:0] amplifier_enable_field, // amplifier enable from the amp register
  input wire logic [2:0] gain_field, // programmed amplifier gain code
  input wire logic conv_valid, // result ready pulse
  input wire logic [23:0] conv_result, // conversion result
  input wire logic [7:0] conv_status, // status byte for the frame
  output mcc_pkg::mcc_analog_t analog, // analog front-end controls
  output logic [4:0] cal_samples, // conversions averaged during calibration
  output logic timeout_enable, // serial timeout enable
  output logic [23:0] offset_trim_value, // offset calibration value
  output logic [23:0] gain_trim_value, // gain calibration value
  output mcc_pkg::mcc_byte_t frame_byte, // outgoing frame byte
  output logic temp_setup_err // temperature monitor chosen with bad amp setup
);

  ////////////////////////////////////////////////////////////////////////////
  mcc_pkg::mcc_sys_t monitor_and_framing_control;
  logic [7:0] sys_bits;
  logic [7:0] ofs_lo, ofs_mid, ofs_hi, gain_lo, gain_mid, gain_hi, pin_io_value;
  assign sys_bits = monitor_and_framing_control;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      monitor_and_framing_control <= `MCC_RST_SYS;
    end else if (wr && addr == `MCC_ADDR_SYS) begin
      monitor_and_framing_control <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ofs_lo <= `MCC_RST_ZERO;
      ofs_mid <= `MCC_RST_ZERO;
      ofs_hi <= `MCC_RST_ZERO;
    end else if (wr) begin
      if (addr == `MCC_ADDR_OFS_LO) ofs_lo <= wdata;
      if (addr == `MCC_ADDR_OFS_MID) ofs_mid <= wdata;
      if (addr == `MCC_ADDR_OFS_HI) ofs_hi <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gain_lo <= `MCC_RST_ZERO;
      gain_mid <= `MCC_RST_ZERO;
      gain_hi <= `MCC_RST_GAIN_HI;
    end else if (wr) begin
      if (addr == `MCC_ADDR_GAIN_LO) gain_lo <= wdata;
      if (addr == `MCC_ADDR_GAIN_MID) gain_mid <= wdata;
      if (addr == `MCC_ADDR_GAIN_HI) gain_hi <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_io_value <= `MCC_RST_ZERO;
    end else if (wr && addr == `MCC_ADDR_PIN_IO) begin
      pin_io_value <= wdata;
    end
  end

  // low byte first: byte registers map straight onto the value slices
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      offset_trim_value <= {`MCC_RST_ZERO, `MCC_RST_ZERO, `MCC_RST_ZERO};
      gain_trim_value <= {`MCC_RST_GAIN_HI, `MCC_RST_ZERO, `MCC_RST_ZERO};
    end else begin
      offset_trim_value <= {ofs_hi, ofs_mid, ofs_lo};
      gain_trim_value <= {gain_hi, gain_mid, gain_lo};
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= `MCC_RST_ZERO;
    end else if (rd) begin
      case (addr)
        `MCC_ADDR_SYS: rdata <= sys_bits;
        `MCC_ADDR_OFS_LO: rdata <= ofs_lo;
        `MCC_ADDR_OFS_MID: rdata <= ofs_mid;
        `MCC_ADDR_OFS_HI: rdata <= ofs_hi;
        `MCC_ADDR_GAIN_LO: rdata <= gain_lo;
        `MCC_ADDR_GAIN_MID: rdata <= gain_mid;
        `MCC_ADDR_GAIN_HI: rdata <= gain_hi;
        `MCC_ADDR_PIN_IO: rdata <= pin_io_value;
        default: rdata <= `MCC_RST_ZERO;
      endcase
    end else begin
      rdata <= `MCC_RST_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  mcc_pkg::mcc_analog_t next_analog;
  always_comb begin
    next_analog = '0;
    next_analog.eff_gain = gain_field;
    case (monitor_and_framing_control.monitor_select)
      `MCC_MON_OFF: next_analog.mux_open = 1'b0;
      `MCC_MON_SHORT: begin
        next_analog.mid_short = 1'b1;
        next_analog.mux_open = 1'b1;
      end
      `MCC_MON_TEMP: begin
        next_analog.temp_sense = 1'b1;
        next_analog.mux_open = 1'b1;
      end
      `MCC_MON_AVDD: begin
        next_analog.avdd_mon = 1'b1;
        next_analog.mux_open = 1'b1;
        next_analog.eff_gain = `MCC_GAIN_UNITY;
      end
      `MCC_MON_DVDD: begin
        next_analog.dvdd_mon = 1'b1;
        next_analog.mux_open = 1'b1;
        next_analog.eff_gain = `MCC_GAIN_UNITY;
      end
      `MCC_MON_BO_LOW: next_analog.burnout_sel = 3'h1;
      `MCC_MON_BO_MID: next_analog.burnout_sel = 3'h2;
      `MCC_MON_BO_HIGH: next_analog.burnout_sel = 3'h4;
      default: next_analog.mux_open = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      analog <= '0;
    end else begin
      analog <= next_analog;
    end
  end

  // the device does not fix a bad host setup; it only flags it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      temp_setup_err <= 1'b0;
    end else begin
      temp_setup_err <= (monitor_and_framing_control.monitor_select == `MCC_MON_TEMP) &&
        ((amplifier_enable_field != `MCC_AMP_ON) || (gain_field > `MCC_GAIN_MAX_TEMP));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cal_samples <= `MCC_AVG_8;
      timeout_enable <= 1'b0;
    end else begin
      case (monitor_and_framing_control.calibration_average_count)
        2'h0: cal_samples <= `MCC_AVG_1;
        2'h1: cal_samples <= `MCC_AVG_4;
        2'h2: cal_samples <= `MCC_AVG_8;
        default: cal_samples <= `MCC_AVG_16;
      endcase
      timeout_enable <= monitor_and_framing_control.timeout_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // framing options are sampled at frame start so a mid-frame write cannot tear it
  mcc_pkg::mcc_state_t state;
  logic [23:0] res_q;
  logic [7:0] stat_q, crc;
  logic [1:0] idx;
  logic use_stat, use_crc;
  logic [7:0] cur_byte, next_crc;

  always_comb begin
    case (idx)
      2'h0: cur_byte = res_q[23:16];
      2'h1: cur_byte = res_q[15:8];
      default: cur_byte = res_q[7:0];
    endcase
  end

  mcc_crc8 u_crc (
    .crc_in(crc),
    .data_in(state == mcc_pkg::MCC_STAT ? stat_q : cur_byte),
    .crc_out(next_crc)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= mcc_pkg::MCC_IDLE;
      res_q <= '0;
      stat_q <= `MCC_RST_ZERO;
      crc <= `MCC_CRC_INIT;
      idx <= 2'h0;
      use_stat <= 1'b0;
      use_crc <= 1'b0;
      frame_byte <= '0;
    end else begin
      frame_byte <= '0;
      case (state)
        mcc_pkg::MCC_IDLE: begin
          if (conv_valid) begin
            res_q <= conv_result;
            stat_q <= conv_status;
            use_stat <= monitor_and_framing_control.status_prefix_enable;
            use_crc <= monitor_and_framing_control.checksum_enable;
            crc <= `MCC_CRC_INIT;
            idx <= 2'h0;
            state <= monitor_and_framing_control.status_prefix_enable ? mcc_pkg::MCC_STAT : mcc_pkg::MCC_DATA;
          end
        end
        mcc_pkg::MCC_STAT: begin
          frame_byte <= '{valid: 1'b1, data: stat_q, last: 1'b0};
          crc <= next_crc;
          state <= mcc_pkg::MCC_DATA;
        end
        mcc_pkg::MCC_DATA: begin
          frame_byte <= '{valid: 1'b1, data: cur_byte, last: (idx == 2'h2) && !use_crc};
          crc <= next_crc;
          idx <= idx + 2'h1;
          if (idx == 2'h2) state <= use_crc ? mcc_pkg::MCC_CHK : mcc_pkg::MCC_DONE;
        end
        mcc_pkg::MCC_CHK: begin
          frame_byte <= '{valid: 1'b1, data: crc, last: 1'b1};
          state <= mcc_pkg::MCC_DONE;
        end
        mcc_pkg::MCC_DONE: state <= mcc_pkg::MCC_IDLE;
        default: state <= mcc_pkg::MCC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a result is taken only from idle; the frame checks below all start there
  logic take_frame;
  assign take_frame = (state == mcc_pkg::MCC_IDLE) && conv_valid;

  supply_gain_a: assert property (@(posedge clk) disable iff (!reset_n)
    (monitor_and_framing_control.monitor_select inside {`MCC_MON_AVDD, `MCC_MON_DVDD})
      |=> analog.eff_gain == `MCC_GAIN_UNITY && analog.mux_open)
    else $error("supply monitor without unity gain");
  mux_open_a: assert property (@(posedge clk) disable iff (!reset_n)
    (monitor_and_framing_control.monitor_select inside {[`MCC_MON_SHORT:`MCC_MON_DVDD]}) |=> analog.mux_open)
    else $error("multiplexer not open during monitor");
  mon_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_OFF |=> !analog.mux_open && analog.burnout_sel == 3'h0 && !analog.mid_short)
    else $error("monitor active while disabled");
  short_gain_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_SHORT |=> analog.mid_short && analog.eff_gain == $past(gain_field))
    else $error("mid-supply short wrong or user gain lost");
  temp_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_TEMP |=> analog.temp_sense && analog.eff_gain == $past(gain_field))
    else $error("temperature sensor not routed");
  avdd_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_AVDD |=> analog.avdd_mon && !analog.dvdd_mon)
    else $error("analog supply monitor not routed");
  dvdd_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_DVDD |=> analog.dvdd_mon && !analog.avdd_mon)
    else $error("digital supply monitor not routed");
  burnout_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_BO_HIGH |=> analog.burnout_sel == 3'h4 && !analog.mux_open)
    else $error("wrong burn-out source");
  burnout_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_BO_LOW |=> analog.burnout_sel == 3'h1 && !analog.mux_open)
    else $error("wrong low burn-out source");
  burnout_mid_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_BO_MID |=> analog.burnout_sel == 3'h2 && analog.eff_gain == $past(gain_field))
    else $error("wrong mid burn-out source");
  temp_err_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_TEMP && gain_field > `MCC_GAIN_MAX_TEMP |=> temp_setup_err)
    else $error("temperature gain fault not flagged");
  temp_ok_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.monitor_select == `MCC_MON_TEMP && amplifier_enable_field == `MCC_AMP_ON && gain_field <= `MCC_GAIN_MAX_TEMP
      |=> !temp_setup_err)
    else $error("legal temperature setup flagged");
  avg_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.calibration_average_count == 2'h1 |=> cal_samples == `MCC_AVG_4)
    else $error("wrong averaging count");
  avg_one_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.calibration_average_count == 2'h0 |=> cal_samples == `MCC_AVG_1)
    else $error("single sample count wrong");
  avg_max_a: assert property (@(posedge clk) disable iff (!reset_n)
    monitor_and_framing_control.calibration_average_count == 2'h3 |=> cal_samples == `MCC_AVG_16)
    else $error("largest sample count wrong");
  timeout_rst_a: assert property (@(posedge clk)
    !reset_n |=> !timeout_enable && cal_samples == `MCC_AVG_8)
    else $error("timeout or averaging reset wrong");
  timeout_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> timeout_enable == $past(monitor_and_framing_control.timeout_enable))
    else $error("timeout enable does not follow its bit");
  gain_rst_a: assert property (@(posedge clk)
    !reset_n ##1 reset_n |=> gain_trim_value == {`MCC_RST_GAIN_HI, `MCC_RST_ZERO, `MCC_RST_ZERO})
    else $error("gain trim reset wrong");
  gain_low_wr_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr && addr == `MCC_ADDR_GAIN_LO |=> ##1 gain_trim_value[7:0] == $past(wdata, 2))
    else $error("gain low byte not placed");
  offset_wr_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr && addr == `MCC_ADDR_OFS_HI |=> ##1 offset_trim_value[23:16] == $past(wdata, 2))
    else $error("offset high byte not placed");
  offset_low_wr_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr && addr == `MCC_ADDR_OFS_LO |=> ##1 offset_trim_value[7:0] == $past(wdata, 2))
    else $error("offset low byte not placed");
  stat_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_frame && monitor_and_framing_control.status_prefix_enable |=> ##1 frame_byte.data == $past(conv_status, 2))
    else $error("status byte not first");
  result_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_frame && !monitor_and_framing_control.status_prefix_enable
      |=> ##1 frame_byte.valid && frame_byte.data == $past(conv_result[23:16], 2))
    else $error("result top byte not first");
  result_msb_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_frame && monitor_and_framing_control.status_prefix_enable |=> ##2 frame_byte.data == $past(conv_result[23:16], 3))
    else $error("result top byte not after status");
  crc_last_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_frame && monitor_and_framing_control.checksum_enable && !monitor_and_framing_control.status_prefix_enable |=> ##4 frame_byte.valid && frame_byte.last)
    else $error("crc byte not at end");
  crc_full_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_frame && monitor_and_framing_control.checksum_enable && monitor_and_framing_control.status_prefix_enable |=> ##5 frame_byte.valid && frame_byte.last)
    else $error("crc byte not at end of full frame");
  plain_last_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_frame && !monitor_and_framing_control.checksum_enable && !monitor_and_framing_control.status_prefix_enable
      |=> ##3 frame_byte.last && frame_byte.data == $past(conv_result[7:0], 4))
    else $error("bare frame does not end on result low byte");

  cov_full_frame: cover property (@(posedge clk) disable iff (!reset_n)
    take_frame && monitor_and_framing_control.status_prefix_enable && monitor_and_framing_control.checksum_enable);
  cov_temp: cover property (@(posedge clk) disable iff (!reset_n) analog.temp_sense);
  cov_supply: cover property (@(posedge clk) disable iff (!reset_n) analog.dvdd_mon);
  cov_short: cover property (@(posedge clk) disable iff (!reset_n) analog.mid_short);
  cov_burnout: cover property (@(posedge clk) disable iff (!reset_n) analog.burnout_sel == 3'h4);
endmodule : mcc_ctrl

// ---- dv/mcc_ctrl_tb_top.sv ----
// self-checking bench for the monitor and calibration control bank
// assumes the register constants header and the shared package are compiled first
`timescale 1ns/1ns
`include "mcc_regs.svh"
module mcc_ctrl_tb_top;
  logic clk, reset_n, wr, rd, conv_valid;
  logic [7:0] addr, wdata, rdata, conv_status;
  logic [1:0] amplifier_enable_field;
  logic [2:0] gain_field;
  logic [23:0] conv_result, offset_trim_value, gain_trim_value;
  logic [4:0] cal_samples;
  logic timeout_enable, temp_setup_err;
  mcc_pkg::mcc_analog_t analog;
  mcc_pkg::mcc_byte_t frame_byte;
  int n_fail, samples_checked, cycles;
  logic [7:0] r;
  logic [4:0] avg_tab [4];
  mcc_ctrl dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .amplifier_enable_field(amplifier_enable_field), .gain_field(gain_field), .conv_valid(conv_valid),
    .conv_result(conv_result), .conv_status(conv_status), .analog(analog), .cal_samples(cal_samples),
    .timeout_enable(timeout_enable), .offset_trim_value(offset_trim_value), .gain_trim_value(gain_trim_value),
    .frame_byte(frame_byte), .temp_setup_err(temp_setup_err));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task chk_val(input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_val
  task chk_an(input mcc_pkg::mcc_analog_t exp);
    samples_checked++;
    if (analog !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, analog);
    end
  endtask : chk_an
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction : crc_step
  function automatic mcc_pkg::mcc_analog_t exp_an(input logic [2:0] m, input logic [2:0] g);
    mcc_pkg::mcc_analog_t e;
    e = '0;
    e.mid_short = (m == 3'h1);
    e.temp_sense = (m == 3'h2);
    e.avdd_mon = (m == 3'h3);
    e.dvdd_mon = (m == 3'h4);
    e.burnout_sel = (m >= 3'h5) ? (3'h1 << (m - 3'h5)) : 3'h0;
    e.mux_open = (m >= 3'h1) && (m <= 3'h4);
    // supply monitors ignore the programmed gain
    e.eff_gain = (m == 3'h3 || m == 3'h4) ? 3'h0 : g;
    return e;
  endfunction : exp_an
  // one conversion with the chosen framing; a stray result pulse lands mid-frame and must be ignored
  task automatic frame(input logic st_en, input logic crc_en, input logic [23:0] res, input logic [7:0] st);
    logic [7:0] eq [$];
    logic [8:0] gq [$];
    logic [7:0] c;
    wr_reg(`MCC_ADDR_SYS, {3'h0, 2'h2, 1'b0, crc_en, st_en});
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_result <= res;
    conv_status <= st;
    @(posedge clk);
    conv_valid <= 1'b0;
    #1 if (frame_byte.valid === 1'b1) gq.push_back({frame_byte.data, frame_byte.last});
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      conv_valid <= (i == 1);
      #1 if (frame_byte.valid === 1'b1) gq.push_back({frame_byte.data, frame_byte.last});
    end
    if (st_en) eq.push_back(st);
    eq.push_back(res[23:16]);
    eq.push_back(res[15:8]);
    eq.push_back(res[7:0]);
    c = 8'h00;
    foreach (eq[i]) c = crc_step(c, eq[i]);
    if (crc_en) eq.push_back(c);
    chk_val(eq.size(), gq.size());
    foreach (eq[i]) if (i < gq.size()) chk_val({eq[i], i == eq.size() - 1}, gq[i]);
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    reset_n = 0;
    wr = 0;
    rd = 0;
    addr = 0;
    wdata = 0;
    conv_valid = 0;
    conv_result = 0;
    conv_status = 0;
    amplifier_enable_field = 0;
    gain_field = 0;
    avg_tab = '{`MCC_AVG_1, `MCC_AVG_4, `MCC_AVG_8, `MCC_AVG_16};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    chk_val(`MCC_AVG_8, cal_samples);
    chk_val(1'b0, timeout_enable);
    chk_val(24'h000000, offset_trim_value);
    chk_val(24'h400000, gain_trim_value);
    chk_an(exp_an(3'h0, 3'h0));
    rd_reg(`MCC_ADDR_SYS, r);
    chk_val(8'h10, r);
    for (int a = 8'h0A; a <= 8'h10; a++) begin
      rd_reg(a[7:0], r);
      chk_val((a == 8'h0F) ? 8'h40 : 8'h00, r);
    end
    // every monitor code with a large user gain, so forced unity gain shows
    @(posedge clk);
    amplifier_enable_field <= `MCC_AMP_ON;
    gain_field <= 3'h5;
    for (int m = 0; m < 8; m++) begin
      wr_reg(`MCC_ADDR_SYS, {m[2:0], 2'h2, 3'h0});
      settle();
      chk_an(exp_an(m[2:0], 3'h5));
      chk_val(m == 2, temp_setup_err);
    end
    // temperature monitor with a legal setup, then with the amplifier off
    wr_reg(`MCC_ADDR_SYS, {3'h2, 2'h2, 3'h0});
    gain_field <= `MCC_GAIN_MAX_TEMP;
    settle();
    chk_val(1'b0, temp_setup_err);
    chk_an(exp_an(3'h2, `MCC_GAIN_MAX_TEMP));
    @(posedge clk);
    amplifier_enable_field <= 2'h0;
    settle();
    chk_val(1'b1, temp_setup_err);
    for (int k = 0; k < 4; k++) begin
      wr_reg(`MCC_ADDR_SYS, {3'h0, k[1:0], k[0], 2'h0});
      settle();
      chk_val(avg_tab[k], cal_samples);
      chk_val(k[0], timeout_enable);
      rd_reg(`MCC_ADDR_SYS, r);
      chk_val({3'h0, k[1:0], k[0], 2'h0}, r);
    end
    // trim bytes back to back, then writes to unmapped places must change nothing
    for (int a = 8'h0A; a <= 8'h0F; a++) wr_reg(a[7:0], 8'hA0 + a[7:0]);
    wr_reg(8'h20, 8'hFF);
    wr_reg(8'hFF, 8'h5A);
    settle();
    chk_val(24'hACABAA, offset_trim_value);
    chk_val(24'hAFAEAD, gain_trim_value);
    for (int a = 8'h0A; a <= 8'h0F; a++) begin
      rd_reg(a[7:0], r);
      chk_val(8'hA0 + a[7:0], r);
    end
    rd_reg(8'h20, r);
    chk_val(8'h00, r);
    wr_reg(`MCC_ADDR_PIN_IO, 8'hC3);
    rd_reg(`MCC_ADDR_PIN_IO, r);
    chk_val(8'hC3, r);
    frame(1'b0, 1'b0, 24'h123456, 8'h81);
    frame(1'b1, 1'b0, 24'hFEDCBA, 8'h42);
    frame(1'b0, 1'b1, 24'h800001, 8'h00);
    frame(1'b1, 1'b1, 24'h00FF00, 8'hC5);
    // second reset in mid-run restores the defaults
    wr_reg(`MCC_ADDR_SYS, 8'hFF);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    chk_val(`MCC_AVG_8, cal_samples);
    chk_val(24'h400000, gain_trim_value);
    chk_val(24'h000000, offset_trim_value);
    rd_reg(`MCC_ADDR_SYS, r);
    chk_val(8'h10, r);
    end_sim();
  end
endmodule : mcc_ctrl_tb_top
